// *** hw/nested_interrupt_controller.sv ***
// Nested interrupt controller with APB priority registers
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_controller
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire nic_pkg::cpu_ctl_t     cpu_ctl,
    output nic_pkg::entry_t            entry,
    output logic      [7:0]            condition_flags,
    output logic                       wake,
    input  wire logic                  top_level_pin_irq,
    input  wire logic [3:0]            ext_pin,
    input  wire logic [3:0]            ext_en,
    input  wire logic [13:0]           periph_flag,
    input  wire logic [13:0]           periph_en,
    input  wire logic [13:0]           periph_clear
);

// ==========================================================
// Pin synchronisers
// ==========================================================
logic       pin_s1_r;
logic       pin_s2_r;
logic       pin_d_r;
logic [3:0] ext_s1_r;
logic [3:0] ext_s2_r;
logic       ext_line_d_r;

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_s1_r     <= 1'b1;
        pin_s2_r     <= 1'b1;
        pin_d_r      <= 1'b1;
        ext_s1_r     <= 4'hf;
        ext_s2_r     <= 4'hf;
        ext_line_d_r <= 1'b0;
    end
    else
    begin
        pin_s1_r     <= top_level_pin_irq;
        pin_s2_r     <= pin_s1_r;
        pin_d_r      <= pin_s2_r;
        ext_s1_r     <= ext_pin;
        ext_s2_r     <= ext_s1_r;
        ext_line_d_r <= ~&(ext_s2_r | ~ext_en);
    end
end

// Falling pin edge chosen for the top-level source
wire pin_edge  = pin_d_r & ~pin_s2_r; // R9
// Any enabled low pin pulls the shared line active
wire ext_line  = ~&(ext_s2_r | ~ext_en); // R13
wire ext_edge  = ext_line & ~ext_line_d_r;

// ==========================================================
// APB register decode
// ==========================================================
logic [27:0] prio_r;
logic [7:0]  flags_r;
logic [13:0] pend_r;
logic        pin_pend_r;
logic        trap_pend_r;

wire [7:0] idx      = paddr[9:2];
wire       acc      = psel & penable;
wire       hit_p0   = (idx == nic_pkg::IDX_PRIO0);
wire       hit_p1   = (idx == nic_pkg::IDX_PRIO1);
wire       hit_p2   = (idx == nic_pkg::IDX_PRIO2);
wire       hit_p3   = (idx == nic_pkg::IDX_PRIO3);
wire       hit_pnd  = (idx == nic_pkg::IDX_PENDING);
wire       hit_flg  = (idx == nic_pkg::IDX_FLAGS);
wire       hit_any  = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0)
                    & (hit_p0 | hit_p1 | hit_p2 | hit_p3 | hit_pnd | hit_flg);
wire       wr_en    = acc & pwrite & hit_any;
wire [3:0] wr_reg   = {hit_p3, hit_p2, hit_p1, hit_p0};

assign pready  = 1'b1;
assign pslverr = acc & ~hit_any;

wire [7:0] rd_p3 = {nic_pkg::PRIO3_FIXED, prio_r[27:24]}; // R18
assign prdata = !hit_any ? 32'h0000_0000 :
                hit_p0   ? {24'h00_0000, prio_r[7:0]} :
                hit_p1   ? {24'h00_0000, prio_r[15:8]} :
                hit_p2   ? {24'h00_0000, prio_r[23:16]} :
                hit_p3   ? {24'h00_0000, rd_p3} :
                hit_pnd  ? {16'h0000, trap_pend_r, pin_pend_r, pend_r} :
                           {24'h00_0000, flags_r};

// ==========================================================
// Per-vector priority, latch and eligibility
// ==========================================================
logic [13:0] elig;
logic [27:0] vlvl;
logic [27:0] prio_nxt;
logic [1:0]  cur_lvl;
logic [3:0]  sel_r;
nic_pkg::entry_state_t state_r;
logic        clr_ext;

// Level from code: 10->0, 01->1, 00->2, 11->3
assign cur_lvl = {~(flags_r[nic_pkg::PRIO_HI_BIT] ^ flags_r[nic_pkg::PRIO_LO_BIT]),
                  flags_r[nic_pkg::PRIO_LO_BIT]}; // R1

genvar g;
generate
    for (g = 0; g < nic_pkg::NVEC; g = g + 1)
    begin : gen_vec
        wire [1:0] code  = prio_r[2*g+1:2*g];
        wire [1:0] wcode = pwdata[2*(g%4)+1:2*(g%4)];
        wire       wsel  = wr_en & wr_reg[g/4];
        // Level-0 code is refused only for this pair
        assign prio_nxt[2*g+1:2*g] = (wsel && wcode != nic_pkg::CODE_LVL0) ?
                                     wcode : code; // R20
        assign vlvl[2*g+1:2*g] = {~(code[1] ^ code[0]), code[0]};
        // Raised level while in service simply wins arbitration again
        assign elig[g] = (g != nic_pkg::PIN_PAIR) // R21
                       & pend_r[g]
                       & (vlvl[2*g+1:2*g] > cur_lvl) // R11 R22 R24
                       & (~cpu_ctl.halt_mode | nic_pkg::HALT_CAP[g]); // R17
        if (g == nic_pkg::EXT_PAIR)
        begin : gen_ext
            // New edge beats the entry clear
            wire set_ext = ext_edge;
            wire clr_e   = clr_ext; // R12
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pend_r[g] <= 1'b0;
                else
                    pend_r[g] <= set_ext | (pend_r[g] & ~clr_e); // R7
            end
        end
        else
        begin : gen_per
            wire set_p = periph_flag[g] & periph_en[g]; // R14
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pend_r[g] <= 1'b0;
                else
                    pend_r[g] <= set_p | (pend_r[g] & ~periph_clear[g]); // R15
            end
        end
    end
endgenerate

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prio_r <= {nic_pkg::PRIO_RESET[3:0], {3{nic_pkg::PRIO_RESET}}}; // R18
    else
        prio_r <= prio_nxt;
end

// ==========================================================
// Arbitration
// ==========================================================
logic [3:0] best_idx;
logic [1:0] best_lvl;
logic       best_ok;

// Descending scan so the lower pair index wins a tie
always_comb
begin
    best_idx = 4'h0;
    best_lvl = 2'h0;
    best_ok  = 1'b0;
    for (int i = nic_pkg::NVEC - 1; i >= 0; i--)
    begin
        if (elig[i] && (!best_ok || vlvl[2*i+1 -: 2] >= best_lvl))
        begin
            best_idx = 4'(i);
            best_lvl = vlvl[2*i+1 -: 2];
            best_ok  = 1'b1;
        end
    end
end // R6

wire nm_any  = pin_pend_r | trap_pend_r;
wire any_req = nm_any | best_ok; // R7
// Sentinel codes above the pair range mark the non-maskable sources
wire [3:0] pick = pin_pend_r ? 4'hf : trap_pend_r ? 4'he : best_idx; // R9

// Halt exit needs halt-capable or the pin interrupt, not the trap; wait takes anything
assign wake = (cpu_ctl.wait_mode & (|pend_r | nm_any))
            | (cpu_ctl.halt_mode & (pin_pend_r | |(pend_r & nic_pkg::HALT_CAP))); // R16

// ==========================================================
// Entry sequencer
// ==========================================================
logic [2:0]  cnt_r;
logic        push_r;
logic        go_r;
logic [15:0] vec_r;
wire         start   = (state_r == nic_pkg::ST_IDLE) & cpu_ctl.instr_done & any_req; // R3
wire         is_nm   = (sel_r == 4'hf) | (sel_r == 4'he);
wire [15:0]  pair_vec = nic_pkg::VEC_PAIR0 - {11'h000, sel_r, 1'b0}; // R2 R19
wire [1:0]   sel_code = prio_r[2*sel_r +: 2];
assign clr_ext = (state_r == nic_pkg::ST_LOAD) & (sel_r == nic_pkg::EXT_PAIR);

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r <= nic_pkg::ST_RESET;
        cnt_r   <= 3'h0;
        sel_r   <= 4'h0;
        push_r  <= 1'b0;
        go_r    <= 1'b0;
        vec_r   <= 16'h0000;
    end
    else
    begin
        push_r <= 1'b0;
        go_r   <= 1'b0;
        case (state_r)
            nic_pkg::ST_RESET:
            begin
                go_r    <= 1'b1;
                vec_r   <= nic_pkg::VEC_RESET; // R10
                state_r <= nic_pkg::ST_IDLE;
            end
            nic_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    sel_r   <= pick;
                    cnt_r   <= 3'h0;
                    push_r  <= 1'b1;
                    state_r <= nic_pkg::ST_STACK;
                end
            end
            nic_pkg::ST_STACK:
            begin
                cnt_r <= cnt_r + 3'h1;
                // Two program counter bytes, index, accumulator, flags
                if (cnt_r == nic_pkg::STACK_BYTES - 3'h1)
                    state_r <= nic_pkg::ST_LOAD;
                else
                    push_r <= 1'b1;
            end
            nic_pkg::ST_LOAD:
            begin
                go_r    <= 1'b1;
                vec_r   <= (sel_r == 4'hf) ? nic_pkg::VEC_PAIR0 :
                           (sel_r == 4'he) ? nic_pkg::VEC_TRAP : pair_vec; // R4
                state_r <= nic_pkg::ST_IDLE;
            end
            default: state_r <= nic_pkg::ST_IDLE;
        endcase
    end
end

assign entry.busy     = (state_r != nic_pkg::ST_IDLE);
assign entry.push     = push_r;
assign entry.push_idx = (state_r == nic_pkg::ST_STACK) ? cnt_r : 3'h0;
assign entry.go       = go_r;
assign entry.vec      = vec_r;

// ==========================================================
// Non-maskable latches and current priority
// ==========================================================
wire load_now = (state_r == nic_pkg::ST_LOAD);

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_pend_r  <= 1'b0;
        trap_pend_r <= 1'b0;
        flags_r     <= nic_pkg::FLAGS_RESET; // R10
    end
    else
    begin
        pin_pend_r  <= pin_edge | (pin_pend_r & ~(load_now & sel_r == 4'hf));
        trap_pend_r <= cpu_ctl.trap_exec | (trap_pend_r & ~(load_now & sel_r == 4'he));
        if (load_now)
        begin
            flags_r[nic_pkg::PRIO_HI_BIT] <= is_nm | sel_code[1]; // R4 R8
            flags_r[nic_pkg::PRIO_LO_BIT] <= is_nm | sel_code[0];
        end
        else if (cpu_ctl.flags_wr)
            flags_r <= cpu_ctl.flags_wdata; // R5 R23
    end
end

assign condition_flags = flags_r;

// ==========================================================
// Assertions
// ==========================================================
property p_reset_vec;
    @(posedge pclk) disable iff (!presetn)
    state_r == nic_pkg::ST_RESET |=> go_r && vec_r == nic_pkg::VEC_RESET
        && cur_lvl == nic_pkg::LVL_TOP;
endproperty
a_reset_vec: assert property (p_reset_vec) else $error("reset vector not issued"); // R10

property p_stack_five;
    @(posedge pclk) disable iff (!presetn)
    start |=> push_r [*5] ##1 !push_r ##1 (go_r && !push_r);
endproperty
a_stack_five: assert property (p_stack_five) else $error("stacking length wrong"); // R3

property p_entry_prio;
    @(posedge pclk) disable iff (!presetn)
    load_now && !is_nm |=> flags_r[nic_pkg::PRIO_HI_BIT] == $past(sel_code[1])
        && flags_r[nic_pkg::PRIO_LO_BIT] == $past(sel_code[0]);
endproperty
a_entry_prio: assert property (p_entry_prio) else $error("priority not loaded"); // R4

property p_nm_level3;
    @(posedge pclk) disable iff (!presetn)
    load_now && is_nm |=> cur_lvl == nic_pkg::LVL_TOP;
endproperty
a_nm_level3: assert property (p_nm_level3) else $error("non-maskable level wrong"); // R8

property p_lvl3_block;
    @(posedge pclk) disable iff (!presetn)
    cur_lvl == nic_pkg::LVL_TOP && !nm_any |-> !best_ok;
endproperty
a_lvl3_block: assert property (p_lvl3_block) else $error("maskable taken at level 3"); // R24

property p_zero_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_p0 && pwdata[3:2] == nic_pkg::CODE_LVL0 |=> $stable(prio_r[3:2]);
endproperty
a_zero_write: assert property (p_zero_write) else $error("level 0 code stored"); // R20

property p_ext_clear;
    @(posedge pclk) disable iff (!presetn)
    clr_ext && !ext_edge |=> !pend_r[nic_pkg::EXT_PAIR];
endproperty
a_ext_clear: assert property (p_ext_clear) else $error("edge latch not cleared"); // R12

property p_halt_wake;
    @(posedge pclk) disable iff (!presetn)
    cpu_ctl.halt_mode && (pin_pend_r || |(pend_r & nic_pkg::HALT_CAP)) |-> wake;
endproperty
a_halt_wake: assert property (p_halt_wake) else $error("halt not exited"); // R16

property p_pin_first;
    @(posedge pclk) disable iff (!presetn)
    start && pin_pend_r |=> sel_r == 4'hf ##6 vec_r == nic_pkg::VEC_PAIR0;
endproperty
a_pin_first: assert property (p_pin_first) else $error("pin interrupt not first"); // R9

property p_ext_latch;
    @(posedge pclk) disable iff (!presetn)
    ext_edge |=> pend_r[nic_pkg::EXT_PAIR];
endproperty
a_ext_latch: assert property (p_ext_latch) else $error("edge not latched"); // R12

property p_halt_first;
    @(posedge pclk) disable iff (!presetn)
    cpu_ctl.halt_mode && start && !nm_any |=> nic_pkg::HALT_CAP[sel_r];
endproperty
a_halt_first: assert property (p_halt_first) else $error("halt exit not capable"); // R17

c_nested:   cover property (@(posedge pclk) disable iff (!presetn) load_now && !is_nm ##[1:40] start);
c_ext_take: cover property (@(posedge pclk) disable iff (!presetn) clr_ext);
c_trap:     cover property (@(posedge pclk) disable iff (!presetn) load_now && sel_r == 4'he);
c_halt:     cover property (@(posedge pclk) disable iff (!presetn) cpu_ctl.halt_mode && wake);

endmodule
`default_nettype wire

// *** common/nic_pkg.sv ***
// Constants and carrier types for the nested interrupt controller
// Notes on behaviour
// R1 - Current priority in flag bits 5 and 3
// R2 - Four levels, sixteen fixed vectors FFE0h-FFFFh
// R3 - Finish instruction, then stack five context bytes
// R4 - Load vector priority and vector address
// R5 - Return pops flags, restoring previous priority
// R6 - Highest software level wins, hardware breaks ties
// R7 - Unserviced requests stay latched until highest
// R8 - Reset, pin, trap ignore mask, set level3
// R9 - Pin edge interrupt; trap alike, pin preempts trap
// R10 - Reset runs at highest priority, level three
// R11 - Maskable taken only when above current level
// R12 - External edge latch cleared on entry
// R13 - Shared external pins combine by NAND
// R14 - Peripheral request is flag and enable
// R15 - Peripheral clearing sequence drops pending latch
// R16 - Any wakes wait; halt-capable wake halt
// R17 - After halt, halt-capable request served first
// R18 - Four priority registers reset FFh, upper nibble
// R19 - Pair 0 serves FFFAh, descending to pair 13
// R20 - Level-0 code writes ignored per pair
// R21 - Pin interrupt pair stored, not used
// R22 - Raised priority while in service re-enters
// R23 - Software instructions may rewrite current priority
// R24 - Level three blocks every maskable request
package nic_pkg;
    localparam int          NVEC         = 14;
    localparam int          NEXT         = 4;
    localparam int          PRIO_HI_BIT  = 5;
    localparam int          PRIO_LO_BIT  = 3;
    localparam logic [7:0]  FLAGS_RESET  = 8'hea;
    localparam logic [7:0]  PRIO_RESET   = 8'hff;
    localparam logic [3:0]  PRIO3_FIXED  = 4'hf;
    localparam logic [1:0]  CODE_LVL0    = 2'h2;
    localparam logic [1:0]  LVL_TOP      = 2'h3;
    localparam logic [7:0]  IDX_PRIO0    = 8'h32;
    localparam logic [7:0]  IDX_PRIO1    = 8'h33;
    localparam logic [7:0]  IDX_PRIO2    = 8'h34;
    localparam logic [7:0]  IDX_PRIO3    = 8'h35;
    localparam logic [7:0]  IDX_PENDING  = 8'h36;
    localparam logic [7:0]  IDX_FLAGS    = 8'h37;
    localparam logic [15:0] VEC_RESET    = 16'hfffe;
    localparam logic [15:0] VEC_TRAP     = 16'hfffc;
    localparam logic [15:0] VEC_PAIR0    = 16'hfffa;
    localparam logic [3:0]  PIN_PAIR     = 4'h0;
    localparam logic [3:0]  EXT_PAIR     = 4'h2;
    localparam logic [13:0] HALT_CAP     = 14'h000e;
    localparam logic [2:0]  STACK_BYTES  = 3'h5;

    typedef enum logic [1:0]
    {
        ST_RESET = 2'b00,
        ST_IDLE  = 2'b01,
        ST_STACK = 2'b10,
        ST_LOAD  = 2'b11
    } entry_state_t;

    typedef struct packed
    {
        logic       instr_done;
        logic       trap_exec;
        logic       flags_wr;
        logic [7:0] flags_wdata;
        logic       halt_mode;
        logic       wait_mode;
    } cpu_ctl_t;

    typedef struct packed
    {
        logic        busy;
        logic        push;
        logic [2:0]  push_idx;
        logic        go;
        logic [15:0] vec;
    } entry_t;
endpackage

// *** testbench/cpu_core_model.sv ***
// CPU core model: instruction ends, flag writes and stacking monitor
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire nic_pkg::entry_t entry,
    input  wire logic            flags_wr_req,
    input  wire logic [7:0]      flags_wdata_req,
    input  wire logic            trap_req,
    input  wire logic            halt_req,
    input  wire logic            wait_req,
    output nic_pkg::cpu_ctl_t    cpu_ctl,
    output logic      [3:0]      push_cnt,
    output logic      [7:0]      go_cnt,
    output logic                 idx_bad
);
    logic [1:0] phase_r;
    logic [3:0] acc_r;

    // ==========================================
    // Requests to the controller
    // Four-cycle instructions; none end while stacking
    assign cpu_ctl.instr_done = (phase_r == 2'h3) && !entry.busy;
    assign cpu_ctl.trap_exec  = trap_req;
    assign cpu_ctl.flags_wr    = flags_wr_req;
    assign cpu_ctl.flags_wdata = flags_wdata_req;
    assign cpu_ctl.halt_mode   = halt_req;
    assign cpu_ctl.wait_mode   = wait_req;

    // ==========================================
    // Stacking monitor
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r  <= 2'h0;
            acc_r    <= 4'h0;
            push_cnt <= 4'h0;
            go_cnt   <= 8'h00;
            idx_bad  <= 1'b0;
        end
        else
        begin
            phase_r <= phase_r + 2'h1;
            acc_r   <= entry.go ? 4'h0 : acc_r + {3'h0, entry.push};
            // Stacked bytes must be numbered in order
            if (entry.push && {1'b0, entry.push_idx} != acc_r)
                idx_bad <= 1'b1;
            if (entry.go)
            begin
                push_cnt <= acc_r;
                go_cnt   <= go_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the nested interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    nic_pkg::cpu_ctl_t cpu_ctl;
    nic_pkg::entry_t   entry;
    logic [7:0]        condition_flags, fwd, go_cnt;
    logic              wake, top_pin, er, fwr, trap, halt, idle_wait, idx_bad;
    logic [3:0]        ext_pin, push_cnt, xen;
    logic [13:0]       pflag, pclr;
    int                fail_count, num_checks;

    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    nested_interrupt_controller u_dut
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .cpu_ctl           (cpu_ctl),
        .entry             (entry),
        .condition_flags   (condition_flags),
        .wake              (wake),
        .top_level_pin_irq (top_pin),
        .ext_pin           (ext_pin),
        .ext_en            (xen),
        .periph_flag       (pflag),
        .periph_en         (14'h3fff),
        .periph_clear      (pclr)
    );

    cpu_core_model u_cpu
    (
        .pclk            (pclk),
        .presetn         (presetn),
        .entry           (entry),
        .flags_wr_req    (fwr),
        .flags_wdata_req (fwd),
        .trap_req        (trap),
        .halt_req        (halt),
        .wait_req        (idle_wait),
        .cpu_ctl         (cpu_ctl),
        .push_cnt        (push_cnt),
        .go_cnt          (go_cnt),
        .idx_bad         (idx_bad)
    );

    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    function automatic logic [11:0] ra(input int i);
        return {2'h0, nic_pkg::IDX_PRIO0 + 8'(i), 2'h0};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, 32'(pready));
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic set_flags(input logic [7:0] v);
        fwr <= 1'b1;
        fwd <= v;
        @(posedge pclk);
        fwr <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic clr(input int j);
        pflag[j] <= 1'b0;
        pclr[j]  <= 1'b1;
        @(posedge pclk);
        pclr[j] <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_go(input logic [15:0] v, input logic [3:0] p, input logic [1:0] c);
        logic [7:0] g;
        int         n;
        g = go_cnt;
        n = 0;
        while (go_cnt === g && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        chk("go_wait", 32'h0, 32'(n >= 300));
        chk("vec", 32'(v), 32'(entry.vec));
        chk("pushes", 32'(p), 32'(push_cnt));
        chk("push_order", 32'h0, 32'(idx_bad));
        chk("level", 32'(c), 32'({condition_flags[5], condition_flags[3]}));
    endtask

    task automatic no_go(input int n);
        logic [7:0] g;
        g = go_cnt;
        repeat (n) @(posedge pclk);
        chk("no_entry", 32'(g), 32'(go_cnt));
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, ra(i), 32'h0);
            chk("prio_reset", 32'hff, rd);
        end
        apb(1'b1, ra(3), 32'h0);
        apb(1'b0, ra(3), 32'h0);
        chk("prio3_upper", 32'hf0, rd);
        apb(1'b1, ra(1), 32'hcf);
        apb(1'b1, ra(1), 32'h64);
        apb(1'b0, ra(1), 32'h0);
        chk("lvl0_write", 32'h44, rd);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
    endtask

    task automatic t_periph();
        apb(1'b1, ra(1), 32'hf7);
        set_flags(8'he2);
        pflag[5] <= 1'b1;
        wait_go(16'hfff0, 4'h5, 2'h1);
        no_go(20);
        clr(5);
        set_flags(8'he2);
        no_go(20);
    endtask

    task automatic t_arb();
        apb(1'b1, ra(1), 32'h4d);
        set_flags(8'he2);
        pflag[4] <= 1'b1;
        pflag[6] <= 1'b1;
        wait_go(16'hffee, 4'h5, 2'h0);
        clr(6);
        set_flags(8'he2);
        wait_go(16'hfff2, 4'h5, 2'h1);
        clr(4);
        set_flags(8'he2);
        pflag[4] <= 1'b1;
        pflag[7] <= 1'b1;
        wait_go(16'hfff2, 4'h5, 2'h1);
        clr(4);
        clr(7);
    endtask

    task automatic t_nmi();
        apb(1'b1, ra(2), 32'hfc);
        set_flags(8'hea);
        pflag[8] <= 1'b1;
        no_go(20);
        trap <= 1'b1;
        @(posedge pclk);
        trap <= 1'b0;
        wait_go(16'hfffc, 4'h5, 2'h3);
        top_pin <= 1'b0;
        wait_go(16'hfffa, 4'h5, 2'h3);
        top_pin <= 1'b1;
        clr(8);
    endtask

    task automatic t_ext();
        apb(1'b1, ra(0), 32'hdf);
        set_flags(8'he2);
        ext_pin[0] <= 1'b0;
        wait_go(16'hfff6, 4'h5, 2'h1);
        set_flags(8'he2);
        no_go(20);
        ext_pin[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_pin[1] <= 1'b0;
        wait_go(16'hfff6, 4'h5, 2'h1);
        ext_pin[1] <= 1'b1;
    endtask

    task automatic t_halt();
        apb(1'b1, ra(0), 32'hd7);
        apb(1'b1, ra(1), 32'h4c);
        halt <= 1'b1;
        set_flags(8'he2);
        pflag[4] <= 1'b1;
        no_go(20);
        chk("wake_blocked", 32'h0, 32'(wake));
        idle_wait <= 1'b1;
        @(posedge pclk);
        chk("wake_wait", 32'h1, 32'(wake));
        idle_wait <= 1'b0;
        pflag[1] <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("wake_capable", 32'h1, 32'(wake));
        wait_go(16'hfff8, 4'h5, 2'h1);
        halt <= 1'b0;
        wait_go(16'hfff2, 4'h5, 2'h0);
        clr(1);
        clr(4);
    endtask

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        {presetn, psel, penable, pwrite, fwr, trap, halt, idle_wait} = 8'h00;
        {paddr, pwdata, fwd} = 52'h0;
        {pflag, pclr} = 28'h0;
        top_pin = 1'b1;
        xen = 4'h3;
        ext_pin = 4'hf;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wait_go(16'hfffe, 4'h0, 2'h3);
        t_regs();
        t_periph();
        t_arb();
        t_nmi();
        t_ext();
        t_halt();
        complete_run();
    end

    // Generous bound: the scenarios need a few hundred cycles
    initial
    begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
